// ---- sim/dma_ack_model.sv ----
// dma controller stand-in: accepts each channel request after a set delay
// assumes level requests on the bus clock; accept is a one-cycle pulse
`timescale 1ns/10ps
module dma_ack_model #(
  parameter int NDMA = 4
) (
  input wire logic clk, // bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic [NDMA-1:0] req, // request per channel
  input wire logic [3:0] lat, // cycles before accepting
  output logic [NDMA-1:0] ack // accept pulse per channel
);
  logic [3:0] cnt_r [NDMA];
  logic [NDMA-1:0] wait_r;
  ////////////////////////////////////////////////////////////////////////////
  // channels set up beforehand: fixed halfword source, basic cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= '0;
      wait_r <= '0;
      for (int i = 0; i < NDMA; i++) cnt_r[i] <= 4'h0;
    end else begin
      for (int i = 0; i < NDMA; i++) begin
        ack[i] <= 1'b0;
        if (!req[i]) begin
          wait_r[i] <= 1'b0;
          cnt_r[i] <= 4'h0;
        end else if (!wait_r[i]) begin
          // one accept per raised request
          if (cnt_r[i] == lat) begin
            ack[i] <= 1'b1;
            wait_r[i] <= 1'b1;
          end else begin
            cnt_r[i] <= cnt_r[i] + 4'h1;
          end
        end
      end
    end
  end
endmodule : dma_ack_model

// ---- sim/pwm_timer_events_bench.sv ----
// self-checking bench for the timer event, output and clock block
// assumes design on one 40 MHz clock, apb with one access cycle
`timescale 1ns/10ps
module pwm_timer_events_bench;
  logic SYS_CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000, PRDATA, q;
  logic PREADY, PSLVERR, IRQ, COUNT_TICK, e, w;
  logic CNT_MAX = 0, CNT_ZERO = 0, DEBUG_HALT = 0;
  logic [1:0] CNT_MODE = 2'h0, CMP_MATCH = 2'h0, CAP_EVENT = 2'h0, TIMER_OUT, CAP_MODE;
  logic [3:0] DMA_ACK, DMA_REQ, lat = 4'h2;
  logic [7:0] sc = 8'h00;
  logic [5:0] SRC_CLK;
  int miscompares = 0, n_tests = 0, cyc = 0, ticks = 0;
  pwm_timer_pkg::out_act_e am [8] = '{pwm_timer_pkg::ACT_NONE, pwm_timer_pkg::ACT_SET,
    pwm_timer_pkg::ACT_TGL, pwm_timer_pkg::ACT_SET, pwm_timer_pkg::ACT_TGL,
    pwm_timer_pkg::ACT_CLR, pwm_timer_pkg::ACT_TGL, pwm_timer_pkg::ACT_CLR};
  pwm_timer_pkg::out_act_e az [8] = '{pwm_timer_pkg::ACT_CLR, pwm_timer_pkg::ACT_NONE,
    pwm_timer_pkg::ACT_CLR, pwm_timer_pkg::ACT_CLR, pwm_timer_pkg::ACT_NONE,
    pwm_timer_pkg::ACT_NONE, pwm_timer_pkg::ACT_SET, pwm_timer_pkg::ACT_SET};
  pwm_timer_events dut_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CNT_MAX(CNT_MAX), .CNT_ZERO(CNT_ZERO), .CNT_MODE(CNT_MODE),
    .CMP_MATCH(CMP_MATCH), .CAP_EVENT(CAP_EVENT), .DEBUG_HALT(DEBUG_HALT),
    .SRC_CLK(SRC_CLK), .DMA_ACK(DMA_ACK), .DMA_REQ(DMA_REQ), .IRQ(IRQ),
    .TIMER_OUT(TIMER_OUT), .CAP_MODE(CAP_MODE), .COUNT_TICK(COUNT_TICK));
  dma_ack_model dma_u (.clk(SYS_CLK), .rst_n(NRST), .req(DMA_REQ), .lat(lat), .ack(DMA_ACK));
  ////////////////////////////////////////////////////////////////////////////
  // clock, source clock at one eighth rate, tick counter, hang guard
  always #12.5 SYS_CLK = ~SYS_CLK;
  assign SRC_CLK = {6{sc[2]}};
  always @(posedge SYS_CLK) begin
    sc <= sc + 8'h01;
    cyc++;
    if (COUNT_TICK === 1'b1) ticks++;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer: setup, access held until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 50) chk(0, 1);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(q, exp);
    chk(e, 1'b0);
  endtask : rd
  // one-cycle event pulses: 0 max, 1 zero, 2 match0, 3 capture0
  task automatic ev(input logic [3:0] b);
    @(posedge SYS_CLK);
    {CAP_EVENT[0], CMP_MATCH[0], CNT_ZERO, CNT_MAX} <= b;
    @(posedge SYS_CLK);
    {CAP_EVENT[0], CMP_MATCH[0], CNT_ZERO, CNT_MAX} <= 4'h0;
  endtask : ev
  task automatic settle(input int n);
    repeat (n - 1) @(posedge SYS_CLK);
    #1;
  endtask : settle
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge SYS_CLK);
    NRST <= 1'b1;
    rd(pwm_timer_pkg::OFS_CLK, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFS_CLK, 32'hFFFFFFFF);
    rd(pwm_timer_pkg::OFS_CLK, 32'h1F7);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(e, 1); // unmapped place refused
    // capture with dma on channel 0, then overwrite without dma
    apb(1'b1, pwm_timer_pkg::OFS_CCTL0, 32'h1);
    apb(1'b1, pwm_timer_pkg::OFS_CCDMA0, 32'h1);
    ev(4'h8);
    settle(1);
    chk(DMA_REQ, 32'h1);
    settle(8);
    chk(DMA_REQ, 32'h0);
    rd(pwm_timer_pkg::OFS_FLAGS, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFS_CCDMA0, 32'h0);
    ev(4'h8);
    ev(4'h8);
    rd(pwm_timer_pkg::OFS_FLAGS, 32'hC);
    apb(1'b1, pwm_timer_pkg::OFS_FLAGS, 32'h8);
    rd(pwm_timer_pkg::OFS_FLAGS, 32'h4);
    apb(1'b1, pwm_timer_pkg::OFS_FLAGS, 32'h4);
    rd(pwm_timer_pkg::OFS_FLAGS, 32'h0);
    // interrupt from max flag only while enabled
    apb(1'b1, pwm_timer_pkg::OFS_IRQEN, 32'h1);
    ev(4'h1);
    settle(1);
    chk(IRQ, 1);
    ev(4'h2);
    apb(1'b1, pwm_timer_pkg::OFS_FLAGS, 32'h1);
    settle(2);
    chk(IRQ, 0);
    rd(pwm_timer_pkg::OFS_FLAGS, 32'h2);
    apb(1'b1, pwm_timer_pkg::OFS_IRQEN, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFS_FLAGS, 32'h3);
    // max/zero requests on channel 1 per count mode, prompt and slow accept
    apb(1'b1, pwm_timer_pkg::OFS_MZDMA, 32'h2);
    for (int k = 0; k < 3; k++) begin
      @(posedge SYS_CLK);
      CNT_MODE <= 2'(k);
      lat <= 4'(k * 3);
      for (int z = 0; z < 2; z++) begin
        ev(4'(1 << z));
        settle(1);
        chk(DMA_REQ, {(z == 1) == (k == 1), 1'b0});
        settle(10);
        chk(DMA_REQ, 32'h0);
        apb(1'b1, pwm_timer_pkg::OFS_FLAGS, 32'h3);
      end
    end
    apb(1'b1, pwm_timer_pkg::OFS_MZDMA, 32'h0);
    // every output mode: match, max, match, match from a cleared wave
    for (int md = 0; md < 8; md++) begin
      apb(1'b1, pwm_timer_pkg::OFS_CCTL0, 32'h0);
      apb(1'b1, pwm_timer_pkg::OFS_CCTL0, 32'(md << 1));
      w = 1'b0;
      for (int s = 0; s < 4; s++) begin
        ev(s == 1 ? 4'h1 : 4'h4);
        case (s == 1 ? az[md] : am[md])
          pwm_timer_pkg::ACT_SET: w = 1'b1;
          pwm_timer_pkg::ACT_CLR: w = 1'b0;
          pwm_timer_pkg::ACT_TGL: w = ~w;
          default: w = w;
        endcase
        settle(3);
        chk(TIMER_OUT[0], w);
      end
    end
    // pair match, polarity, capture mode holds the pin inactive
    apb(1'b1, pwm_timer_pkg::OFS_CCTL0, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFS_CCTL0 + 12'h4, 32'h12);
    ev(4'h4);
    settle(3);
    chk(TIMER_OUT, 32'h2);
    apb(1'b1, pwm_timer_pkg::OFS_CCTL0 + 12'h4, 32'h32);
    settle(3);
    chk(TIMER_OUT, 32'h0);
    rd(pwm_timer_pkg::OFS_CCTL0 + 12'h4, 32'h32);
    apb(1'b1, pwm_timer_pkg::OFS_CCTL0, 32'h27);
    ev(4'h4);
    settle(3);
    chk({CAP_MODE, TIMER_OUT}, 32'h5);
    // counter clock: source 0 divided by 4, debug halt gating, inverted source 1/1
    for (int t = 0; t < 4; t++) begin
      @(posedge SYS_CLK);
      DEBUG_HALT <= (t == 1 || t == 2);
      apb(1'b1, pwm_timer_pkg::OFS_CLK, t == 3 ? 32'h0F6 : (t == 2 ? 32'h120 : 32'h020));
      repeat (20) @(posedge SYS_CLK);
      #1;
      ticks = 0;
      repeat (512) @(posedge SYS_CLK);
      #1;
      chk(t == 1 ? ticks <= 1 : (t == 3 ? ticks >= 62 && ticks <= 66
          : ticks >= 15 && ticks <= 17), 1);
    end
    conclude();
  end
endmodule : pwm_timer_events_bench

// ---- verilog/pwm_timer_events.sv ----
// event flags, dma requests, timer outputs and clock control of one channel
// assumes counter core pulses on SYS_CLK and an apb master on the same clock
// Function
// - capture event with capture dma enable for a channel requests that channel
// - timer outputs only driven in comparator mode, from match and max/zero
// - two, four or six independent output circuits per channel
// - three-bit output mode selects waveform action on match and max/zero
// - pair match select uses the partner circuit's match signal
// - polarity bit zero gives active high, one gives active low
// - capture while compare/capture flag set sets overwrite flag; write one clears
// - compare/capture flag sets on match or capture; write one clears
// - max and zero flags set on counter events; write one clears
// - interrupt raised only while an enabled flag is set
// - dma sources: compare/capture always, max in up modes, zero in down
// - one enable per compare/capture flag per dma channel, plus one shared by max and zero, gates that channel's request
// - debug run bit 8 keeps the clock running in debug halt
// - divider field bits 7 to 4 selects the counter clock ratio
// - source field bits 2 to 0 selects oscillator or external clock
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module pwm_timer_events #(
  parameter int NCIRC = 2,
  parameter int NDMA = 4,
  parameter int NSRC = 6
) (
  input wire logic SYS_CLK, // 40 MHz bus clock
  input wire logic NRST, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire logic CNT_MAX, // counter reached max, pulse
  input wire logic CNT_ZERO, // counter reached zero, pulse
  input wire logic [1:0] CNT_MODE, // up, down or up/down
  input wire logic [NCIRC-1:0] CMP_MATCH, // comparator match, pulse
  input wire logic [NCIRC-1:0] CAP_EVENT, // capture loaded, pulse
  input wire logic DEBUG_HALT, // processor halted in debug
  input wire logic [NSRC-1:0] SRC_CLK, // raw clock source pins
  input wire logic [NDMA-1:0] DMA_ACK, // dma accepted request, pulse
  output logic [NDMA-1:0] DMA_REQ, // dma request per channel
  output logic IRQ, // interrupt request
  output logic [NCIRC-1:0] TIMER_OUT, // timer output pins
  output logic [NCIRC-1:0] CAP_MODE, // circuit in capture mode
  output logic COUNT_TICK // counter clock enable pulse
);
  localparam int NFL = 2 + 2 * NCIRC;

  // effective divider code: fast sources divide fully, osc B up to DIV_MAX_OSC_B, others undivided
  function automatic logic [3:0] eff_div(input logic [2:0] src, input logic [3:0] div);
    if (src == pwm_timer_pkg::SRC_OSC_A || src == pwm_timer_pkg::SRC_OSC_FAST) begin
      eff_div = div;
    end else if (src == pwm_timer_pkg::SRC_OSC_B && div <= pwm_timer_pkg::DIV_MAX_OSC_B) begin
      eff_div = div;
    end else begin
      eff_div = 4'h0;
    end
  endfunction : eff_div

  // action for one event class under a given mode
  function automatic pwm_timer_pkg::out_act_e mode_act(input logic [2:0] md,
                                                       input logic on_match);
    case (md)
      3'h1: mode_act = on_match ? pwm_timer_pkg::ACT_SET : pwm_timer_pkg::ACT_NONE;
      3'h2: mode_act = on_match ? pwm_timer_pkg::ACT_TGL : pwm_timer_pkg::ACT_CLR;
      3'h3: mode_act = on_match ? pwm_timer_pkg::ACT_SET : pwm_timer_pkg::ACT_CLR;
      3'h4: mode_act = on_match ? pwm_timer_pkg::ACT_TGL : pwm_timer_pkg::ACT_NONE;
      3'h5: mode_act = on_match ? pwm_timer_pkg::ACT_CLR : pwm_timer_pkg::ACT_NONE;
      3'h6: mode_act = on_match ? pwm_timer_pkg::ACT_TGL : pwm_timer_pkg::ACT_SET;
      3'h7: mode_act = on_match ? pwm_timer_pkg::ACT_CLR : pwm_timer_pkg::ACT_SET;
      default: mode_act = on_match ? pwm_timer_pkg::ACT_NONE : pwm_timer_pkg::ACT_CLR;
    endcase
  endfunction : mode_act

  logic [8:0] clk_r;
  logic [NFL-1:0] flags_r, flags_nxt, irqen_r;
  logic [NDMA-1:0] mzdma_r, req_nxt;
  logic [5:0] cctl_r [NCIRC];
  logic [NDMA-1:0] ccdma_r [NCIRC];
  logic [NCIRC-1:0] wave_r;
  logic [31:0] rdata_nxt;
  logic hit_nxt, wr_en;
  logic [NSRC-1:0] s1_r, s2_r, s3_r;
  logic [14:0] pre_r;
  logic src_edge;
  logic [2:0] src;
  logic [3:0] div;

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

  // read mux and decode
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (PADDR)
      pwm_timer_pkg::OFS_CLK: rdata_nxt[8:0] = clk_r;
      pwm_timer_pkg::OFS_FLAGS: rdata_nxt[NFL-1:0] = flags_r;
      pwm_timer_pkg::OFS_IRQEN: rdata_nxt[NFL-1:0] = irqen_r;
      pwm_timer_pkg::OFS_MZDMA: rdata_nxt[NDMA-1:0] = mzdma_r;
      default: hit_nxt = 1'b0;
    endcase
    for (int m = 0; m < NCIRC; m++) begin
      if (PADDR == pwm_timer_pkg::OFS_CCTL0 + 12'(m * pwm_timer_pkg::REG_STEP)) begin
        rdata_nxt[5:0] = cctl_r[m];
        hit_nxt = 1'b1;
      end
      if (PADDR == pwm_timer_pkg::OFS_CCDMA0 + 12'(m * pwm_timer_pkg::REG_STEP)) begin
        rdata_nxt[NDMA-1:0] = ccdma_r[m];
        hit_nxt = 1'b1;
      end
    end
  end

  // one wait-free access phase: answer captured in setup cycle
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit_nxt;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // software control registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      clk_r <= pwm_timer_pkg::CLK_RESET;
      irqen_r <= '0;
      mzdma_r <= '0;
      for (int m = 0; m < NCIRC; m++) begin
        cctl_r[m] <= pwm_timer_pkg::CC_RESET;
        ccdma_r[m] <= '0;
      end
    end else if (wr_en) begin
      if (PADDR == pwm_timer_pkg::OFS_CLK) clk_r <= PWDATA[8:0] & pwm_timer_pkg::CLK_WMASK;
      if (PADDR == pwm_timer_pkg::OFS_IRQEN) irqen_r <= PWDATA[NFL-1:0];
      if (PADDR == pwm_timer_pkg::OFS_MZDMA) mzdma_r <= PWDATA[NDMA-1:0];
      for (int m = 0; m < NCIRC; m++) begin
        if (PADDR == pwm_timer_pkg::OFS_CCTL0 + 12'(m * pwm_timer_pkg::REG_STEP)) begin
          cctl_r[m] <= PWDATA[5:0];
        end
        if (PADDR == pwm_timer_pkg::OFS_CCDMA0 + 12'(m * pwm_timer_pkg::REG_STEP)) begin
          ccdma_r[m] <= PWDATA[NDMA-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags and dma requests
  always_comb begin
    logic max_dma, zero_dma;
    max_dma = (CNT_MODE == pwm_timer_pkg::CNT_UP) || (CNT_MODE == pwm_timer_pkg::CNT_UPDOWN);
    zero_dma = (CNT_MODE == pwm_timer_pkg::CNT_DOWN);
    flags_nxt = flags_r;
    req_nxt = '0;
    // clears first: write one, or dma accepted
    if (wr_en && PADDR == pwm_timer_pkg::OFS_FLAGS) flags_nxt = flags_r & ~PWDATA[NFL-1:0];
    if (max_dma && |(DMA_ACK & mzdma_r)) flags_nxt[pwm_timer_pkg::FL_MAX] = 1'b0;
    if (zero_dma && |(DMA_ACK & mzdma_r)) flags_nxt[pwm_timer_pkg::FL_ZERO] = 1'b0;
    for (int m = 0; m < NCIRC; m++) begin
      if (|(DMA_ACK & ccdma_r[m])) flags_nxt[pwm_timer_pkg::FL_CC0 + 2 * m] = 1'b0;
    end
    // sets win over clears
    if (CNT_MAX) flags_nxt[pwm_timer_pkg::FL_MAX] = 1'b1;
    if (CNT_ZERO) flags_nxt[pwm_timer_pkg::FL_ZERO] = 1'b1;
    for (int m = 0; m < NCIRC; m++) begin
      if (cctl_r[m][pwm_timer_pkg::CC_CAPMODE_BIT] ? CAP_EVENT[m] : CMP_MATCH[m]) begin
        flags_nxt[pwm_timer_pkg::FL_CC0 + 2 * m] = 1'b1;
      end
      if (cctl_r[m][pwm_timer_pkg::CC_CAPMODE_BIT] && CAP_EVENT[m]
          && flags_r[pwm_timer_pkg::FL_CC0 + 2 * m]) begin
        flags_nxt[pwm_timer_pkg::FL_OW0 + 2 * m] = 1'b1;
      end
    end
    // per channel request from the updated flags
    for (int x = 0; x < NDMA; x++) begin
      req_nxt[x] = mzdma_r[x] && ((max_dma && flags_nxt[pwm_timer_pkg::FL_MAX])
                   || (zero_dma && flags_nxt[pwm_timer_pkg::FL_ZERO]));
      for (int m = 0; m < NCIRC; m++) begin
        if (ccdma_r[m][x] && flags_nxt[pwm_timer_pkg::FL_CC0 + 2 * m]) req_nxt[x] = 1'b1;
      end
    end
  end

  // flag, request and interrupt registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      flags_r <= '0;
      DMA_REQ <= '0;
      IRQ <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      DMA_REQ <= req_nxt;
      IRQ <= |(flags_nxt & irqen_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer output circuits
  genvar g;
  generate
    for (g = 0; g < NCIRC; g++) begin : g_out
      logic match_sel;
      pwm_timer_pkg::out_act_e act_m, act_z;
      // partner of g is g xor 1
      assign match_sel = cctl_r[g][pwm_timer_pkg::CC_PAIR_BIT] ? CMP_MATCH[g ^ 1]
                         : CMP_MATCH[g];
      assign act_m = match_sel ? mode_act(cctl_r[g][3:1], 1'b1) : pwm_timer_pkg::ACT_NONE;
      assign act_z = (CNT_MAX || CNT_ZERO) ? mode_act(cctl_r[g][3:1], 1'b0)
                     : pwm_timer_pkg::ACT_NONE;
      // waveform state, match action takes priority
      always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          wave_r[g] <= 1'b0;
        end else if (cctl_r[g][pwm_timer_pkg::CC_CAPMODE_BIT]
                     || cctl_r[g][3:1] == 3'h0) begin
          wave_r[g] <= 1'b0;
        end else begin
          case (act_m != pwm_timer_pkg::ACT_NONE ? act_m : act_z)
            pwm_timer_pkg::ACT_SET: wave_r[g] <= 1'b1;
            pwm_timer_pkg::ACT_CLR: wave_r[g] <= 1'b0;
            pwm_timer_pkg::ACT_TGL: wave_r[g] <= !wave_r[g];
            default: wave_r[g] <= wave_r[g];
          endcase
        end
      end
      // polarity applied at the pin flop
      always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          TIMER_OUT[g] <= 1'b0;
          CAP_MODE[g] <= 1'b0;
        end else begin
          TIMER_OUT[g] <= wave_r[g] ^ cctl_r[g][pwm_timer_pkg::CC_POL_BIT];
          CAP_MODE[g] <= cctl_r[g][pwm_timer_pkg::CC_CAPMODE_BIT];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // clock source synchroniser, three stages
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= SRC_CLK;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign src = clk_r[pwm_timer_pkg::CLK_SRC_LSB +: pwm_timer_pkg::CLK_SRC_W];
  assign div = eff_div(src, clk_r[pwm_timer_pkg::CLK_DIV_LSB +: pwm_timer_pkg::CLK_DIV_W]);

  // source edge; inverted inputs count falling edges
  always_comb begin
    int i;
    i = (src >= pwm_timer_pkg::SRC_INV0) ? int'(src) - 2 : int'(src);
    src_edge = 1'b0;
    if (i < NSRC) begin
      src_edge = (src >= pwm_timer_pkg::SRC_INV0) ? (!s2_r[i] && s3_r[i])
                 : (s2_r[i] && !s3_r[i]);
    end
  end

  // prescaler, stopped in debug halt unless debug run
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pre_r <= '0;
      COUNT_TICK <= 1'b0;
    end else if (DEBUG_HALT && !clk_r[pwm_timer_pkg::CLK_DEBUG_RUN_BIT]) begin
      COUNT_TICK <= 1'b0;
    end else if (src_edge) begin
      pre_r <= pre_r + 15'h0001;
      COUNT_TICK <= ((pre_r & ((15'h0001 << div) - 15'h0001))
                     == ((15'h0001 << div) - 15'h0001));
    end else begin
      COUNT_TICK <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  a_irq_gate: assert property (IRQ |-> |(flags_r & $past(irqen_r)))
    else $error("irq without enabled flag");
  a_max_set: assert property (CNT_MAX |=> flags_r[pwm_timer_pkg::FL_MAX])
    else $error("max flag not set");
  a_zero_set: assert property (CNT_ZERO |=> flags_r[pwm_timer_pkg::FL_ZERO])
    else $error("zero flag not set");
  a_cc_cap_set: assert property (cctl_r[0][0] && CAP_EVENT[0] |=> flags_r[pwm_timer_pkg::FL_CC0])
    else $error("capture flag not set");
  a_ow_set: assert property (cctl_r[0][0] && CAP_EVENT[0] && flags_r[pwm_timer_pkg::FL_CC0]
                             |=> flags_r[pwm_timer_pkg::FL_OW0])
    else $error("overwrite flag not set");
  a_ow_cause: assert property ($rose(flags_r[pwm_timer_pkg::FL_OW0])
                               |-> $past(CAP_EVENT[0] && flags_r[pwm_timer_pkg::FL_CC0]))
    else $error("overwrite without cause");
  a_dma_cap: assert property (cctl_r[0][0] && CAP_EVENT[0] && ccdma_r[0][0] |=> DMA_REQ[0])
    else $error("capture dma missing");
  a_dma_en: assert property (DMA_REQ[0] |-> $past(mzdma_r[0] || ccdma_r[0][0]))
    else $error("dma without enable");
  a_ack_clr: assert property (!CNT_MAX && !CNT_ZERO && !CMP_MATCH[0] && !CAP_EVENT[0]
                              && DMA_ACK[0] && ccdma_r[0][0]
                              |=> !flags_r[pwm_timer_pkg::FL_CC0])
    else $error("ack did not clear flag");
  a_cap_out_low: assert property (cctl_r[0][0] ##1 cctl_r[0][0]
                                  |=> TIMER_OUT[0] == $past(cctl_r[0][5]))
    else $error("output active in capture mode");
  a_halt_stop: assert property (DEBUG_HALT && !clk_r[8] |=> !COUNT_TICK)
    else $error("tick during debug halt");
  // write one to the overwrite flag clears it when no new overwrite lands
  a_ow_clr: assert property (wr_en && PADDR == pwm_timer_pkg::OFS_FLAGS
                             && PWDATA[pwm_timer_pkg::FL_OW0] && !(cctl_r[0][0] && CAP_EVENT[0])
                             |=> !flags_r[pwm_timer_pkg::FL_OW0])
    else $error("overwrite flag not cleared");
  // circuit 1 in set-on-match mode follows the match of circuit 0 when paired
  a_pair_sel: assert property (!cctl_r[1][0] && cctl_r[1][4] && cctl_r[1][3:1] == 3'h1
                               && CMP_MATCH[0] |=> wave_r[1])
    else $error("pair match not used");

  c_capture_dma: cover property (DMA_REQ[0] ##[1:8] DMA_ACK[0]);
  c_overwrite: cover property ($rose(flags_r[pwm_timer_pkg::FL_OW0]));
  c_out_toggle: cover property ($rose(TIMER_OUT[0]) ##[1:50] $fell(TIMER_OUT[0]));
  c_irq: cover property ($rose(IRQ));
endmodule : pwm_timer_events

// ---- verilog/pwm_timer_pkg.sv ----
// constants for the pwm timer event and output block
// assumes a 32-bit apb slave with byte addresses
package pwm_timer_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CLK = 12'h000;
  localparam logic [11:0] OFS_FLAGS = 12'h004;
  localparam logic [11:0] OFS_IRQEN = 12'h008;
  localparam logic [11:0] OFS_MZDMA = 12'h00C;
  localparam logic [11:0] OFS_CCTL0 = 12'h010;
  localparam logic [11:0] OFS_CCDMA0 = 12'h030;
  localparam int REG_STEP = 4;
  // clock control fields
  localparam int CLK_DEBUG_RUN_BIT = 8;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_DIV_W = 4;
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_SRC_W = 3;
  localparam logic [8:0] CLK_RESET = 9'h000;
  localparam logic [8:0] CLK_WMASK = 9'h1F7;
  // circuit control fields
  localparam int CC_CAPMODE_BIT = 0;
  localparam int CC_MODE_LSB = 1;
  localparam int CC_MODE_W = 3;
  localparam int CC_PAIR_BIT = 4;
  localparam int CC_POL_BIT = 5;
  localparam logic [5:0] CC_RESET = 6'h00;
  // flag positions: max, zero, then per circuit compare/capture, overwrite
  localparam int FL_MAX = 0;
  localparam int FL_ZERO = 1;
  localparam int FL_CC0 = 2;
  localparam int FL_OW0 = 3;
  // count modes from the counter core
  localparam logic [1:0] CNT_UP = 2'h0;
  localparam logic [1:0] CNT_DOWN = 2'h1;
  localparam logic [1:0] CNT_UPDOWN = 2'h2;
  // clock sources
  localparam logic [2:0] SRC_OSC_A = 3'h0;
  localparam logic [2:0] SRC_OSC_B = 3'h1;
  localparam logic [2:0] SRC_OSC_FAST = 3'h2;
  localparam logic [3:0] DIV_MAX_OSC_B = 4'h8;
  localparam logic [2:0] SRC_INV0 = 3'h6;
  // output actions per event
  typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_SET = 2'h1, ACT_CLR = 2'h2,
                            ACT_TGL = 2'h3} out_act_e;
endpackage : pwm_timer_pkg
